// ---- dv/rllc_regs_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module rllc_regs_test;
    logic       ref_clk;
    logic       rstn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       free_run_mode;
    logic [9:0] tracked_voltage;
    logic       line_sync;
    logic [3:0] pll_locked;
    logic [9:0] loop_filter_pin;
    logic       adc_disable;
    logic       dac_disable;
    logic       sync_missing;
    logic       reference_loss;
    logic       lock_loss;
    logic       global_lock;
    int         mismatches;
    int         n_tests;
    logic [7:0] d;
    // Line-sync period used by the loss tests, in clocks
    localparam int PER = 40;

    rllc_regs rllc_regs_inst (
        .ref_clk         (ref_clk),
        .rstn            (rstn),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_rdata       (reg_rdata),
        .free_run_mode   (free_run_mode),
        .tracked_voltage (tracked_voltage),
        .line_sync       (line_sync),
        .pll_locked      (pll_locked),
        .loop_filter_pin (loop_filter_pin),
        .adc_disable     (adc_disable),
        .dac_disable     (dac_disable),
        .sync_missing    (sync_missing),
        .reference_loss  (reference_loss),
        .lock_loss       (lock_loss),
        .global_lock     (global_lock)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks and comparison
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Two-cycle high pulse on the line-sync pin, the whole task lasting one full period
    task automatic sync_pulse();
        @(posedge ref_clk);
        line_sync <= 1'b1;
        repeat (2) @(posedge ref_clk);
        line_sync <= 1'b0;
        repeat (PER - 3) @(posedge ref_clk);
        #1;
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog, well beyond the expected run length
    initial begin
        #(4 * 30000);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        mismatches      = 0;
        n_tests         = 0;
        rstn            = 1'b0;
        reg_addr        = 8'h00;
        reg_wdata       = 8'h00;
        reg_wr          = 1'b0;
        reg_rd          = 1'b0;
        free_run_mode   = 1'b0;
        tracked_voltage = 10'h0f0;
        line_sync       = 1'b0;
        pll_locked      = 4'h0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);

        // Reset values and an unmapped address
        rd(rllc_pkg::FREE_RUN_VOLTAGE_HIGH_ADDR, d);
        chk(d, 8'h01, "high rst");
        rd(rllc_pkg::FREE_RUN_VOLTAGE_LOW_ADDR, d);
        chk(d, 8'hff, "low rst");
        rd(rllc_pkg::CONVERTER_DISABLE_ADDR, d);
        chk(d, 8'h00, "conv rst");
        rd(rllc_pkg::REFERENCE_LOSS_THRESH_ADDR, d);
        chk(d, 8'h09, "ref rst");
        rd(rllc_pkg::LOCK_LOSS_THRESH_ADDR, d);
        chk(d, 8'h10, "lock rst");
        rd(rllc_pkg::LOCK_ALIGN_MASK_ADDR, d);
        chk(d, 8'h00, "mask rst");
        rd(8'h30, d);
        chk(d, 8'h00, "unmapped");
        chk({adc_disable, dac_disable}, 2'b00, "disables rst");
        $display("Test reset values done");

        // Free-run voltage halves and loop filter drive
        wr(rllc_pkg::FREE_RUN_VOLTAGE_HIGH_ADDR, 8'h02);
        wr(rllc_pkg::FREE_RUN_VOLTAGE_LOW_ADDR, 8'h5a);
        rd(rllc_pkg::FREE_RUN_VOLTAGE_HIGH_ADDR, d);
        chk(d, 8'h02, "high rb");
        rd(rllc_pkg::FREE_RUN_VOLTAGE_LOW_ADDR, d);
        chk(d, 8'h5a, "low rb");
        chk(loop_filter_pin, 10'h0f0, "tracked");
        free_run_mode <= 1'b1;
        wait_clk(5);
        chk(loop_filter_pin, 10'h25a, "free run");
        wr(rllc_pkg::FREE_RUN_VOLTAGE_LOW_ADDR, 8'h33);
        wait_clk(3);
        chk(loop_filter_pin, 10'h233, "low only");
        wr(rllc_pkg::FREE_RUN_VOLTAGE_HIGH_ADDR, 8'h03);
        wait_clk(3);
        chk(loop_filter_pin, 10'h333, "high only");
        free_run_mode <= 1'b0;
        wait_clk(5);
        chk(loop_filter_pin, 10'h0f0, "tracked again");
        $display("Test free-run voltage done");

        // Converter disables, each bit alone
        wr(rllc_pkg::CONVERTER_DISABLE_ADDR, 8'h02);
        wait_clk(2);
        chk({adc_disable, dac_disable}, 2'b10, "adc off");
        wr(rllc_pkg::CONVERTER_DISABLE_ADDR, 8'h01);
        wait_clk(2);
        chk({adc_disable, dac_disable}, 2'b01, "dac off");
        rd(rllc_pkg::CONVERTER_DISABLE_ADDR, d);
        chk(d, 8'h01, "conv rb");
        $display("Test converter disables done");

        // Lock masks: every mask against every lock pattern
        for (int m = 0; m < 16; m++) begin
            wr(rllc_pkg::LOCK_ALIGN_MASK_ADDR, {m[3:0], 4'h0});
            for (int p = 0; p < 16; p++) begin
                @(posedge ref_clk);
                pll_locked <= p[3:0];
                wait_clk(5);
                chk(global_lock, &(p[3:0] | m[3:0]), "global lock");
            end
        end
        rd(rllc_pkg::LOCK_ALIGN_MASK_ADDR, d);
        chk(d, 8'hf0, "mask rb");
        rd(rllc_pkg::STATUS_ADDR, d);
        chk(d[3], 1'b1, "status lock");
        $display("Test lock masks done");

        // Reference and lock loss on missing line sync
        wr(rllc_pkg::REFERENCE_LOSS_THRESH_ADDR, 8'h22);
        wr(rllc_pkg::LOCK_LOSS_THRESH_ADDR, 8'h07);
        rd(rllc_pkg::REFERENCE_LOSS_THRESH_ADDR, d);
        chk(d, 8'h2a, "ref rb");
        rd(rllc_pkg::LOCK_LOSS_THRESH_ADDR, d);
        chk(d, 8'h07, "lock rb");
        repeat (4) sync_pulse();
        chk({sync_missing, reference_loss, lock_loss}, 3'b000, "syncs ok");
        wait_clk(PER / 2);
        chk(sync_missing, 1'b1, "sync missing");
        chk(reference_loss, 1'b0, "one missed");
        // Second missed period lands a full period after the first
        wait_clk(PER);
        chk(reference_loss, 1'b1, "ref lost");
        chk(lock_loss, 1'b0, "lock held");
        rd(rllc_pkg::STATUS_ADDR, d);
        chk(d[2:0], 3'b011, "status loss");
        wait_clk(4 * PER);
        chk(lock_loss, 1'b0, "six missed");
        wait_clk(PER + 10);
        chk(lock_loss, 1'b1, "lock lost");
        sync_pulse();
        chk({sync_missing, reference_loss, lock_loss}, 3'b000, "sync back");
        $display("Test loss detection done");

        // Reference loss limit of 6 rides through five missing pulses
        wr(rllc_pkg::REFERENCE_LOSS_THRESH_ADDR, 8'h06);
        repeat (3) sync_pulse();
        // Between the fifth and the sixth missed period
        wait_clk(5 * PER - 10);
        chk(reference_loss, 1'b0, "five missed");
        wait_clk(PER);
        chk(reference_loss, 1'b1, "six missed ref");
        $display("Test blanking limit done");
        results();
    end
endmodule
`default_nettype wire

// ---- inc/rllc_pkg.sv ----
package rllc_pkg;

    // Register offsets
    localparam logic [7:0] FREE_RUN_VOLTAGE_HIGH_ADDR = 8'h18;
    localparam logic [7:0] FREE_RUN_VOLTAGE_LOW_ADDR  = 8'h19;
    localparam logic [7:0] CONVERTER_DISABLE_ADDR     = 8'h1a;
    localparam logic [7:0] REFERENCE_LOSS_THRESH_ADDR = 8'h1b;
    localparam logic [7:0] LOCK_LOSS_THRESH_ADDR      = 8'h1c;
    localparam logic [7:0] LOCK_ALIGN_MASK_ADDR       = 8'h1d;
    localparam logic [7:0] STATUS_ADDR                = 8'h1e;

    // Field positions
    localparam int DAC_DISABLE_BIT    = 0;
    localparam int ADC_DISABLE_BIT    = 1;
    localparam int SYNC_MISS_LSB      = 4;
    localparam int REF_LOSS_LSB       = 0;
    localparam int RSVD_ONE_BIT       = 3;
    localparam int LOCK_HIDE_LSB      = 4;

    // Reset values
    localparam logic [7:0] FREE_RUN_LOW_RST  = 8'hff;
    localparam logic [1:0] FREE_RUN_HIGH_RST = 2'h1;
    localparam logic [1:0] CONV_DIS_RST      = 2'h0;
    localparam logic [2:0] SYNC_MISS_RST     = 3'h0;
    localparam logic [2:0] REF_LOSS_RST      = 3'h1;
    localparam logic [4:0] LOCK_LOSS_RST     = 5'h10;
    localparam logic [7:0] MASK_RST          = 8'h00;

    // Number of supervised PLLs
    localparam int NUM_PLL = 4;

endpackage

// ---- verilog/rllc_regs.sv ----
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - A write to the low voltage register replaces bits 7:0 of the free-run voltage; reset 0xff.
// - A write to the high voltage register replaces bits 9:8 of the free-run voltage; reset 01.
// - In free-run mode the free-run voltage is driven onto the loop filter output.
// - Converter disable bit 1 drives the holdover ADC disable output; reset zero.
// - Converter disable bit 0 drives the DAC disable output; reset zero.
// - Bits 6:4 of the reference threshold add clocks before the sync-missing flag rises.
// - Bits 2:0 give the missing line-sync periods before reference loss; reset 001.
// - Bits 4:0 of the lock threshold give the periods before lock loss; reset 10000.
// - Mask bit 7 hides the fourth PLL from the global lock flag.
// - Mask bit 6 hides the third PLL from the global lock flag.
// - Mask bits 5 and 4 hide the second and first PLL from the global lock flag.
module rllc_regs (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       free_run_mode,
    input  wire logic [9:0] tracked_voltage,
    input  wire logic       line_sync,
    input  wire logic [3:0] pll_locked,
    output logic      [9:0] loop_filter_pin,
    output logic            adc_disable,
    output logic            dac_disable,
    output logic            sync_missing,
    output logic            reference_loss,
    output logic            lock_loss,
    output logic            global_lock
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic       rst_meta_ff;
    logic       rst_n;
    logic       mode_meta_ff;
    logic       mode_ff;
    logic       sync_meta_ff;
    logic       sync_ff;
    logic       sync_prev_ff;
    logic [3:0] lock_meta_ff;
    logic [3:0] lock_ff;

    // Reset released through two flip-flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_meta_ff <= 1'b0;
            mode_ff      <= 1'b0;
            sync_meta_ff <= 1'b0;
            sync_ff      <= 1'b0;
            sync_prev_ff <= 1'b0;
            lock_meta_ff <= 4'h0;
            lock_ff      <= 4'h0;
        end else begin
            mode_meta_ff <= free_run_mode;
            mode_ff      <= mode_meta_ff;
            sync_meta_ff <= line_sync;
            sync_ff      <= sync_meta_ff;
            sync_prev_ff <= sync_ff;
            lock_meta_ff <= pll_locked;
            lock_ff      <= lock_meta_ff;
        end
    end

    logic sync_rise;
    assign sync_rise = sync_ff & ~sync_prev_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] free_low_ff;
    logic [1:0] free_high_ff;
    logic [1:0] conv_dis_ff;
    logic [2:0] sync_miss_ff;
    logic [2:0] ref_limit_ff;
    logic [4:0] lock_limit_ff;
    logic [7:0] mask_ff;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // Software writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            free_low_ff   <= rllc_pkg::FREE_RUN_LOW_RST;
            free_high_ff  <= rllc_pkg::FREE_RUN_HIGH_RST;
            conv_dis_ff   <= rllc_pkg::CONV_DIS_RST;
            sync_miss_ff  <= rllc_pkg::SYNC_MISS_RST;
            ref_limit_ff  <= rllc_pkg::REF_LOSS_RST;
            lock_limit_ff <= rllc_pkg::LOCK_LOSS_RST;
            mask_ff       <= rllc_pkg::MASK_RST;
        end else if (reg_wr) begin
            if (hit(reg_addr, rllc_pkg::FREE_RUN_VOLTAGE_LOW_ADDR)) begin
                free_low_ff <= reg_wdata;
            end
            if (hit(reg_addr, rllc_pkg::FREE_RUN_VOLTAGE_HIGH_ADDR)) begin
                free_high_ff <= reg_wdata[1:0];
            end
            if (hit(reg_addr, rllc_pkg::CONVERTER_DISABLE_ADDR)) begin
                conv_dis_ff <= reg_wdata[1:0];
            end
            if (hit(reg_addr, rllc_pkg::REFERENCE_LOSS_THRESH_ADDR)) begin
                sync_miss_ff <= reg_wdata[rllc_pkg::SYNC_MISS_LSB +: 3];
                ref_limit_ff <= reg_wdata[rllc_pkg::REF_LOSS_LSB +: 3];
            end
            if (hit(reg_addr, rllc_pkg::LOCK_LOSS_THRESH_ADDR)) begin
                lock_limit_ff <= reg_wdata[4:0];
            end
            if (hit(reg_addr, rllc_pkg::LOCK_ALIGN_MASK_ADDR)) begin
                mask_ff <= reg_wdata;
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                rllc_pkg::FREE_RUN_VOLTAGE_HIGH_ADDR: reg_rdata <= {6'h00, free_high_ff};
                rllc_pkg::FREE_RUN_VOLTAGE_LOW_ADDR:  reg_rdata <= free_low_ff;
                rllc_pkg::CONVERTER_DISABLE_ADDR:     reg_rdata <= {6'h00, conv_dis_ff};
                rllc_pkg::REFERENCE_LOSS_THRESH_ADDR: reg_rdata <= {1'b0, sync_miss_ff, 1'b1,
                                                                    ref_limit_ff};
                rllc_pkg::LOCK_LOSS_THRESH_ADDR:      reg_rdata <= {3'h0, lock_limit_ff};
                rllc_pkg::LOCK_ALIGN_MASK_ADDR:       reg_rdata <= mask_ff;
                rllc_pkg::STATUS_ADDR:                reg_rdata <= {4'h0, global_lock, lock_loss,
                                                                    reference_loss, sync_missing};
                default:                              reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Converter controls and loop filter drive

    // Disable outputs follow the register bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_disable <= 1'b0;
            dac_disable <= 1'b0;
        end else begin
            adc_disable <= conv_dis_ff[rllc_pkg::ADC_DISABLE_BIT];
            dac_disable <= conv_dis_ff[rllc_pkg::DAC_DISABLE_BIT];
        end
    end

    // Free-run voltage in free-run mode, tracked voltage otherwise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_filter_pin <= {rllc_pkg::FREE_RUN_HIGH_RST, rllc_pkg::FREE_RUN_LOW_RST};
        end else if (mode_ff) begin
            loop_filter_pin <= {free_high_ff, free_low_ff};
        end else begin
            loop_filter_pin <= tracked_voltage;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Line-sync period timing

    logic [15:0] period_cnt_ff;
    logic [15:0] period_len_ff;
    logic        period_tick;
    logic        missed_ff;
    logic [2:0]  extra_cnt_ff;

    // Learns the period only across a clean interval, so a sync after a loss keeps it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt_ff <= 16'h0000;
            period_len_ff <= 16'hffff;
            missed_ff     <= 1'b0;
        end else if (sync_rise) begin
            period_len_ff <= missed_ff ? period_len_ff : period_cnt_ff;
            period_cnt_ff <= 16'h0000;
            missed_ff     <= 1'b0;
        end else if (period_tick) begin
            period_cnt_ff <= 16'h0000;
            missed_ff     <= 1'b1;
        end else begin
            period_cnt_ff <= period_cnt_ff + 16'h0001;
        end
    end

    assign period_tick = !sync_rise && (period_cnt_ff >= period_len_ff);

    // Extra clock wait after a missed period before the sync-missing flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            extra_cnt_ff <= 3'h0;
            sync_missing <= 1'b0;
        end else if (sync_rise) begin
            extra_cnt_ff <= 3'h0;
            sync_missing <= 1'b0;
        end else if (period_tick) begin
            extra_cnt_ff <= 3'h1;
            sync_missing <= sync_missing | (sync_miss_ff == 3'h0);
        end else if (extra_cnt_ff != 3'h0) begin
            if (extra_cnt_ff >= sync_miss_ff) begin
                sync_missing <= 1'b1;
                extra_cnt_ff <= 3'h0;
            end else begin
                extra_cnt_ff <= extra_cnt_ff + 3'h1;
            end
        end
    end

    logic ref_trip;
    logic lock_trip;

    // Reference loss counter
    rllc_sync_count #(
        .WIDTH(3)
    ) u_ref_count (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .sync_pulse (sync_rise),
        .period_tick(period_tick),
        .limit      (ref_limit_ff),
        .tripped    (ref_trip)
    );

    // Lock loss counter
    rllc_sync_count #(
        .WIDTH(5)
    ) u_lock_count (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .sync_pulse (sync_rise),
        .period_tick(period_tick),
        .limit      (lock_limit_ff),
        .tripped    (lock_trip)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Lock supervision

    logic [3:0] lock_seen;

    // Masked PLLs count as locked
    genvar g;
    generate
        for (g = 0; g < rllc_pkg::NUM_PLL; g++) begin : g_lock
            assign lock_seen[g] = lock_ff[g]
                                | mask_ff[rllc_pkg::LOCK_HIDE_LSB + g];
        end
    endgenerate

    // Status outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reference_loss <= 1'b0;
            lock_loss      <= 1'b0;
            global_lock    <= 1'b0;
        end else begin
            reference_loss <= ref_trip;
            lock_loss      <= lock_trip;
            global_lock    <= &lock_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_free_run_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mode_ff |=> loop_filter_pin == $past({free_high_ff, free_low_ff}))
        else $error("Loop filter not driven with free-run voltage");

    a_low_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && reg_addr == rllc_pkg::FREE_RUN_VOLTAGE_LOW_ADDR
        |=> free_low_ff == $past(reg_wdata))
        else $error("Low voltage write lost");

    a_high_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr && reg_addr == rllc_pkg::FREE_RUN_VOLTAGE_HIGH_ADDR
        |=> free_high_ff == $past(reg_wdata[1:0]))
        else $error("High voltage write lost");

    sequence s_conv_write;
        reg_wr && reg_addr == rllc_pkg::CONVERTER_DISABLE_ADDR;
    endsequence

    a_adc_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_conv_write ##2 1 |-> adc_disable == $past(reg_wdata[1], 2))
        else $error("ADC disable does not follow register");

    a_dac_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_conv_write ##2 1 |-> dac_disable == $past(reg_wdata[0], 2))
        else $error("DAC disable does not follow register");

    a_sync_extra: assert property (@(posedge ref_clk) disable iff (!rst_n)
        period_tick && sync_miss_ff == 3'h0 |=> sync_missing)
        else $error("Sync missing late with no extra clocks");

    a_ref_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sync_rise |=> ##1 !reference_loss)
        else $error("Reference loss held across a sync pulse");

    a_lock_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sync_rise |=> ##1 !lock_loss)
        else $error("Lock loss held across a sync pulse");

    a_global_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 global_lock == &($past(lock_ff) | $past(mask_ff[7:4])))
        else $error("Global lock ignores mask or PLL state");

    a_pll4_hide: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mask_ff[7] && (&lock_ff[2:0]) && !(|mask_ff[6:4]) |=> global_lock)
        else $error("Hidden fourth PLL still affects lock");

endmodule
`default_nettype wire

// ---- verilog/rllc_sync_count.sv ----
`timescale 1ns/1ps
`default_nettype none
// Counts line-sync periods without a sync pulse and flags when a limit is reached
module rllc_sync_count #(
    parameter int WIDTH = 5
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             sync_pulse,
    input  wire logic             period_tick,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  tripped
);

    logic [WIDTH-1:0] miss_cnt_ff;

    // Missing periods counted between sync pulses, saturating at the limit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            miss_cnt_ff <= '0;
        end else if (sync_pulse) begin
            miss_cnt_ff <= '0;
        end else if (period_tick && miss_cnt_ff < limit) begin
            miss_cnt_ff <= miss_cnt_ff + WIDTH'(1);
        end
    end

    // Tripped once the count reaches a non-zero limit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tripped <= 1'b0;
        end else begin
            tripped <= (limit != '0) && (miss_cnt_ff >= limit) && !sync_pulse;
        end
    end

endmodule
`default_nettype wire
